// ### rtl/sixrx_map.vh
// Constants for the six-channel serial audio receiver.
// Assumes a 100 MHz mclk; included by the receiver module and the checker.
`ifndef SIXRX_MAP_VH
`define SIXRX_MAP_VH
// Format select codes
`define SIXRX_FMT_RJ16 3'h0
`define SIXRX_FMT_RJ20 3'h1
`define SIXRX_FMT_RJ24 3'h2
`define SIXRX_FMT_I2S16 3'h3
`define SIXRX_FMT_I2S20 3'h4
`define SIXRX_FMT_I2S24 3'h5
`define SIXRX_FMT_LJ24 3'h6
`define SIXRX_FMT_DSP16 3'h7
// Speed codes
`define SIXRX_SPD_NORMAL 2'h0
`define SIXRX_SPD_DOUBLE 2'h1
`define SIXRX_SPD_QUAD 2'h2
// Fast clock multiples of master clock
`define SIXRX_MUL_NORMAL 4'h8
`define SIXRX_MUL_DOUBLE 4'h4
`define SIXRX_MUL_QUAD 4'h2
// Bit clocks per frame
`define SIXRX_BPF_48 7'd48
`define SIXRX_BPF_64 7'd64
// Master-mode bit clock half period, mclk cycles
`define SIXRX_MBCLK_HALF 8'h04
// Initialization time, us, and derived cycles at 100 MHz
`define SIXRX_INIT_US 4000
`define SIXRX_MCLK_MHZ 100
`define SIXRX_INIT_CYC (`SIXRX_INIT_US * `SIXRX_MCLK_MHZ)
// Master clock absence timeout, mclk cycles
`define SIXRX_MCK_TIMEOUT 8'hff
// Quad speed threshold: master clock edges per frame below this count
`define SIXRX_QUAD_LIM 12'h040
`define SIXRX_DOUBLE_LIM 12'h0a0
// Defaults restored by initialization
`define SIXRX_DEF_VOL 8'h00
`define SIXRX_DEF_RATIO 9'h100
`define SIXRX_DEF_DELAY 8'h00
`endif

// ### rtl/sixrx_receiver.v
// Six-channel serial audio receiver: three data lines, four framings.
// Assumes bit clock, frame clock and data come from another domain and
// that the master clock of the audio system arrives as a plain pin input.
//
// Notes on behaviour
// - Fast clock is 8x, 4x, 2x master clock
// - Count fast cycles for drift; delay_q only holds its default
// - Receive only, six channels on three lines
// - Samples are MSB first, two's complement
// - Accepts frame rates 32 to 192 kHz
// - Three-bit field selects framing and length
// - Format change starts error recovery
// - I2S low frame clock marks left
// - I2S MSB one bit after frame edge
// - Justified formats accept 48 or 64 bits
// - Data sampled on rising bit clock
// - Trailing bits beyond word length ignored
// - Master mode makes only 64x bit clock
// - Left-justified high is left, MSB at edge
// - Right-justified LSB last before frame edge
// - Right-justified leading bits ignored
// - DSP edge starts frame, left first
// - Reset holds device, ignores traffic
// - 4 ms initialization, waits for master clock
// - Initialization restores documented defaults
// - Master drives clocks, slave takes them
// - Quad speed detected without select input
`timescale 1ns/1ns
`default_nettype none
`include "sixrx_map.vh"
module sixrx_receiver #(
   parameter INIT_CYCLES = `SIXRX_INIT_CYC // Shorten in simulation
) (
   input wire mclk,
   input wire rst,
   input wire power_down_control, // Low holds device powered down
   input wire master_sel, // High selects master clock mode
   input wire double_speed, // High selects double speed
   input wire master_clock_in, // Audio master clock pin
   input wire format_select_bit2,
   input wire format_select_bit1,
   input wire format_select_bit0,
   input wire bit_clock_in,
   output reg bit_clock_out,
   output wire bit_clock_oe,
   input wire frame_clock_in,
   output reg frame_clock_out,
   output wire frame_clock_oe,
   input wire serial_in_line_a,
   input wire serial_in_line_b,
   input wire serial_in_line_c,
   output reg [23:0] ch1_q,
   output reg [23:0] ch2_q,
   output reg [23:0] ch3_q,
   output reg [23:0] ch4_q,
   output reg [23:0] ch5_q,
   output reg [23:0] ch6_q,
   output reg sample_valid_q, // One-cycle pulse per stored frame
   output reg ready_q, // Initialization done
   output reg recovery_q, // One-cycle pulse on format change
   output reg [1:0] speed_q, // Detected speed
   output reg [3:0] fast_mult_q, // Fast clock multiple of master clock
   output reg [7:0] volume_q,
   output reg [8:0] mclk_ratio_q,
   output reg automute_q,
   output reg deemph_q,
   output reg [7:0] dc_offset_q,
   output reg [7:0] delay_q,
   output reg master_mode_q,
   output reg drift_q // Fast cycle count moved more than two master edges between frames
);
   // Init state machine, one-hot
   localparam ST_WAIT = 3'b001;
   localparam ST_INIT = 3'b010;
   localparam ST_RUN = 3'b100;

   // Word length from format code
   function [4:0] fmt_len;
      input [2:0] f;
      begin
         case (f)
            `SIXRX_FMT_RJ16, `SIXRX_FMT_I2S16, `SIXRX_FMT_DSP16: fmt_len = 5'd16;
            `SIXRX_FMT_RJ20, `SIXRX_FMT_I2S20: fmt_len = 5'd20;
            default: fmt_len = 5'd24;
         endcase
      end
   endfunction

   // Three-stage synchroniser with agreement of stages two and three
   reg [2:0] bck_s, lrk_s, mck_s, da_s, db_s, dc_s;
   reg bck_v, lrk_v, mck_v;
   wire [2:0] fmt = {format_select_bit2, format_select_bit1, format_select_bit0};
   reg [2:0] fmt_q; // Format latched while running
   reg [2:0] st_q; // Init state
   reg [31:0] init_cnt_q; // Init time counter
   reg [7:0] mck_idle_q; // Cycles since last master clock edge
   reg [6:0] bit_cnt_q; // Bit clocks since frame edge
   reg [6:0] bpf_q; // Bit clocks in last frame
   reg [11:0] frame_mclk_q; // Master clock edges per frame
   reg [11:0] last_fast_q; // Fast cycles in the last whole frame
   reg seen_q; // A frame start was seen since running
   reg [11:0] fast_cnt_q; // Fast clock cycles since frame edge
   reg [23:0] sr_a_q, sr_b_q, sr_c_q; // Shift registers
   reg [7:0] mdiv_q; // Master-mode divider
   reg [5:0] mbit_q; // Master-mode bit position
   reg lr_prev_q;

   // Edges are judged once stages two and three agree
   wire run = (st_q == ST_RUN);
   wire bck_rise = (bck_s[2] == bck_s[1]) && bck_s[2] && !bck_v;
   wire mck_rise = (mck_s[2] == mck_s[1]) && mck_s[2] && !mck_v;
   wire lr_now = (lrk_s[2] == lrk_s[1]) ? lrk_s[2] : lrk_v;
   wire is_rj = (fmt_q <= `SIXRX_FMT_RJ24);
   wire is_i2s = (fmt_q >= `SIXRX_FMT_I2S16) && (fmt_q <= `SIXRX_FMT_I2S24);
   wire is_dsp = (fmt_q == `SIXRX_FMT_DSP16);
   wire [4:0] wlen = fmt_len(fmt_q);
   // DSP frames are always 64 bits, so the right slot opens at bit 32
   wire [6:0] half = is_dsp ? (`SIXRX_BPF_64 >> 1) : {1'b0, bpf_q[6:1]};
   // Left-marking level: low in I2S, high otherwise; DSP starts on the rise
   wire left_mark = is_i2s ? !lr_now : lr_now;
   wire frame_start = bck_rise && (lr_now != lr_prev_q) && left_mark;
   // Index of the bit arriving now; the bit at the frame edge is bit 0
   wire [6:0] cur_pos = frame_start ? 7'h00 : bit_cnt_q + 7'h01;
   // Position of this bit inside its channel slot
   wire [6:0] slot_pos = (cur_pos >= half) ? cur_pos - half : cur_pos;
   wire second_slot = (cur_pos >= half);
   // Two master edges of slack, in fast cycles, before drift is flagged
   wire [11:0] drift_tol = {7'h00, fast_mult_q, 1'b0};
   // I2S MSB comes one bit late; RJ data sits at the slot end
   wire [6:0] first_bit = is_i2s ? 7'd1 : (is_rj ? half - {2'b00, wlen} : 7'd0);
   wire take = bck_rise && (slot_pos >= first_bit) &&
      (slot_pos < first_bit + {2'b00, wlen});
   // Drive the clocks only in master mode
   assign bit_clock_oe = master_mode_q && run;
   assign frame_clock_oe = master_mode_q && run;

   // Synchronisers; no logic looks at stage one
   always @(posedge mclk) begin
      bck_s <= {bck_s[1:0], bit_clock_in};
      lrk_s <= {lrk_s[1:0], frame_clock_in};
      mck_s <= {mck_s[1:0], master_clock_in};
      da_s <= {da_s[1:0], serial_in_line_a};
      db_s <= {db_s[1:0], serial_in_line_b};
      dc_s <= {dc_s[1:0], serial_in_line_c};
      if (bck_s[2] == bck_s[1]) bck_v <= bck_s[2];
      if (mck_s[2] == mck_s[1]) mck_v <= mck_s[2];
      if (lrk_s[2] == lrk_s[1]) lrk_v <= lrk_s[2];
   end

   // Reset, initialization and defaults
   always @(posedge mclk) begin
      if (rst || !power_down_control) begin
         st_q <= ST_WAIT;
         init_cnt_q <= 32'h0000_0000;
         mck_idle_q <= `SIXRX_MCK_TIMEOUT;
         ready_q <= 1'b0;
         recovery_q <= 1'b0;
         fmt_q <= `SIXRX_FMT_RJ16;
         volume_q <= `SIXRX_DEF_VOL;
         mclk_ratio_q <= `SIXRX_DEF_RATIO;
         automute_q <= 1'b1;
         deemph_q <= 1'b0;
         dc_offset_q <= 8'h00;
         delay_q <= `SIXRX_DEF_DELAY;
         master_mode_q <= 1'b0;
      end else begin
         recovery_q <= 1'b0;
         // Master clock presence watch
         if (mck_rise) mck_idle_q <= 8'h00;
         else if (mck_idle_q != `SIXRX_MCK_TIMEOUT) mck_idle_q <= mck_idle_q + 8'h01;
         case (st_q)
            ST_WAIT: begin
               // Wait for master clock before timing init
               if (mck_idle_q != `SIXRX_MCK_TIMEOUT) st_q <= ST_INIT;
            end
            ST_INIT: begin
               init_cnt_q <= init_cnt_q + 32'h0000_0001;
               if (init_cnt_q == INIT_CYCLES - 1) begin
                  st_q <= ST_RUN;
                  ready_q <= 1'b1;
                  fmt_q <= fmt;
                  master_mode_q <= master_sel;
                  volume_q <= `SIXRX_DEF_VOL;
                  mclk_ratio_q <= `SIXRX_DEF_RATIO;
                  automute_q <= 1'b1;
                  deemph_q <= 1'b0;
                  dc_offset_q <= 8'h00;
                  delay_q <= `SIXRX_DEF_DELAY;
               end
            end
            ST_RUN: begin
               // Format change restarts recovery through init
               if (fmt != fmt_q) begin
                  recovery_q <= 1'b1;
                  ready_q <= 1'b0;
                  init_cnt_q <= 32'h0000_0000;
                  st_q <= ST_INIT;
               end
            end
            default: st_q <= ST_WAIT;
         endcase
      end
   end

   // Master-mode clock generation: 64 bit clocks per frame
   always @(posedge mclk) begin
      if (rst || !run || !master_mode_q) begin
         mdiv_q <= 8'h00;
         mbit_q <= 6'h00;
         bit_clock_out <= 1'b0;
         frame_clock_out <= 1'b0;
      end else if (mdiv_q == `SIXRX_MBCLK_HALF - 8'h01) begin
         mdiv_q <= 8'h00;
         bit_clock_out <= !bit_clock_out;
         if (bit_clock_out) begin
            mbit_q <= mbit_q + 6'h01;
            if (mbit_q == 6'h1f || mbit_q == 6'h3f) frame_clock_out <= !frame_clock_out;
         end
      end else begin
         mdiv_q <= mdiv_q + 8'h01;
      end
   end

   // Frame tracking, speed detection and fast clock counting
   always @(posedge mclk) begin
      if (rst || !run) begin
         lr_prev_q <= 1'b0;
         seen_q <= 1'b0;
         bit_cnt_q <= 7'h00;
         bpf_q <= `SIXRX_BPF_64;
         frame_mclk_q <= 12'h000;
         last_fast_q <= 12'h000;
         fast_cnt_q <= 12'h000;
         speed_q <= `SIXRX_SPD_NORMAL;
         fast_mult_q <= `SIXRX_MUL_NORMAL;
         drift_q <= 1'b0;
      end else begin
         // Fast cycles: each master edge counts the multiple
         if (mck_rise) begin
            frame_mclk_q <= frame_mclk_q + 12'h001;
            fast_cnt_q <= fast_cnt_q + {8'h00, fast_mult_q};
         end
         if (bck_rise) begin
            lr_prev_q <= lr_now;
            bit_cnt_q <= cur_pos;
         end
         // Counts restart at each left-marking edge
         if (frame_start) begin
            seen_q <= 1'b1;
            frame_mclk_q <= 12'h000;
            fast_cnt_q <= 12'h000;
            // First start after init only opens the counts; they are partial
            if (seen_q) begin
               bpf_q <= (bit_cnt_q + 7'h01 > 7'd56) ? `SIXRX_BPF_64 : `SIXRX_BPF_48;
               last_fast_q <= fast_cnt_q;
               drift_q <= (last_fast_q != 12'h000) &&
                  (fast_cnt_q > last_fast_q + drift_tol || last_fast_q > fast_cnt_q + drift_tol);
               // Speed from master clocks per frame, no select pin for quad
               if (frame_mclk_q < `SIXRX_QUAD_LIM && !double_speed) begin
                  speed_q <= `SIXRX_SPD_QUAD;
                  fast_mult_q <= `SIXRX_MUL_QUAD;
               end else if (double_speed) begin
                  speed_q <= `SIXRX_SPD_DOUBLE;
                  fast_mult_q <= `SIXRX_MUL_DOUBLE;
               end else begin
                  speed_q <= `SIXRX_SPD_NORMAL;
                  fast_mult_q <= `SIXRX_MUL_NORMAL;
               end
            end
         end
      end
   end

   // Shift in the three lines, one stereo pair each
   always @(posedge mclk) begin
      if (rst || !run) begin
         sr_a_q <= 24'h00_0000;
         sr_b_q <= 24'h00_0000;
         sr_c_q <= 24'h00_0000;
         sample_valid_q <= 1'b0;
         ch1_q <= 24'h00_0000;
         ch2_q <= 24'h00_0000;
         ch3_q <= 24'h00_0000;
         ch4_q <= 24'h00_0000;
         ch5_q <= 24'h00_0000;
         ch6_q <= 24'h00_0000;
      end else begin
         sample_valid_q <= 1'b0;
         if (take) begin
            // MSB first; word left-aligned in 24 bits, signed
            sr_a_q <= {sr_a_q[22:0], da_s[2]};
            sr_b_q <= {sr_b_q[22:0], db_s[2]};
            sr_c_q <= {sr_c_q[22:0], dc_s[2]};
            if (slot_pos == first_bit + {2'b00, wlen} - 7'd1) begin
               if (!second_slot) begin
                  ch1_q <= {sr_a_q[22:0], da_s[2]} << (5'd24 - wlen);
                  ch3_q <= {sr_b_q[22:0], db_s[2]} << (5'd24 - wlen);
                  ch5_q <= {sr_c_q[22:0], dc_s[2]} << (5'd24 - wlen);
               end else begin
                  ch2_q <= {sr_a_q[22:0], da_s[2]} << (5'd24 - wlen);
                  ch4_q <= {sr_b_q[22:0], db_s[2]} << (5'd24 - wlen);
                  ch6_q <= {sr_c_q[22:0], dc_s[2]} << (5'd24 - wlen);
                  sample_valid_q <= 1'b1;
               end
            end
         end
      end
   end
endmodule // sixrx_receiver
`default_nettype wire

// ### tb/sixrx_asserts.sv
// Checker for the six-channel receiver: timing relations at its ports.
// Assumes a 100 MHz mclk; attached to every receiver instance by bind.
`timescale 1ns/1ns
`default_nettype none
`include "sixrx_map.vh"
module sixrx_asserts #(
   parameter int INIT_CYCLES = 50
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic power_down_control,
   input wire logic master_sel,
   input wire logic format_select_bit2,
   input wire logic format_select_bit1,
   input wire logic format_select_bit0,
   input wire logic frame_clock_out,
   input wire logic frame_clock_oe,
   input wire logic bit_clock_oe,
   input wire logic sample_valid_q,
   input wire logic ready_q,
   input wire logic recovery_q,
   input wire logic [1:0] speed_q,
   input wire logic [3:0] fast_mult_q,
   input wire logic [7:0] volume_q,
   input wire logic [8:0] mclk_ratio_q,
   input wire logic automute_q,
   input wire logic deemph_q,
   input wire logic [7:0] dc_offset_q,
   input wire logic [7:0] delay_q,
   input wire logic master_mode_q
);
   logic [31:0] wait_q; // Cycles spent not ready
   // Wait counter; cleared by reset or readiness
   always @(posedge mclk) begin
      if (rst || ready_q)
         wait_q <= 32'h0000_0000;
      else
         wait_q <= wait_q + 32'h0000_0001;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst || !power_down_control);
   // Format moved while running
   sequence s_fmt_move;
      ready_q && !$stable({format_select_bit2, format_select_bit1, format_select_bit0});
   endsequence
   // Speed settled; the multiple is set in the same cycle as the speed
   sequence s_spd_held;
      (ready_q && $stable(speed_q)) [*4];
   endsequence
   a_reset_clears: assert property (disable iff (1'b0) rst |=> !ready_q && !sample_valid_q && automute_q)
      else $error("outputs active after reset");
   a_valid_pulse: assert property (sample_valid_q |-> ready_q ##1 !sample_valid_q)
      else $error("sample valid wrong");
   a_fmt_recovery: assert property (s_fmt_move |-> ##[0:2] recovery_q ##[1:3] !ready_q)
      else $error("no recovery on format change");
   a_mult_speed: assert property (s_spd_held |-> fast_mult_q == (speed_q == `SIXRX_SPD_NORMAL ? `SIXRX_MUL_NORMAL
      : (speed_q == `SIXRX_SPD_DOUBLE ? `SIXRX_MUL_DOUBLE : `SIXRX_MUL_QUAD)))
      else $error("fast multiple wrong");
   a_master_oe: assert property (bit_clock_oe == (master_mode_q && ready_q) && frame_clock_oe == bit_clock_oe)
      else $error("clock enable wrong");
   a_init_defaults: assert property ($rose(ready_q) |-> volume_q == `SIXRX_DEF_VOL && automute_q && !deemph_q
      && mclk_ratio_q == `SIXRX_DEF_RATIO && dc_offset_q == 8'h00 && delay_q == `SIXRX_DEF_DELAY
      && master_mode_q == master_sel)
      else $error("defaults wrong");
   a_init_length: assert property ($rose(ready_q) |-> wait_q >= INIT_CYCLES)
      else $error("init too short");
   a_frame_period: assert property (frame_clock_oe && $changed(frame_clock_out) |-> ##256
      ($changed(frame_clock_out) || !frame_clock_oe))
      else $error("frame not 64 bits");
endmodule // sixrx_asserts
bind sixrx_receiver sixrx_asserts #(.INIT_CYCLES(INIT_CYCLES)) u_sixrx_asserts (.mclk, .rst, .power_down_control,
   .master_sel, .format_select_bit2, .format_select_bit1, .format_select_bit0, .frame_clock_out, .frame_clock_oe,
   .bit_clock_oe, .sample_valid_q, .ready_q, .recovery_q, .speed_q, .fast_mult_q, .volume_q, .mclk_ratio_q,
   .automute_q, .deemph_q, .dc_offset_q, .delay_q, .master_mode_q);
`default_nettype wire

// ### tb/sixrx_src.sv
// Audio source model: bit clock, frame clock and three data lines.
// Assumes the receiver is in slave mode while send runs.
`timescale 1ns/1ns
`default_nettype none
module sixrx_src (
   output logic bclk,
   output logic lrclk,
   output logic [2:0] sd
);
   int bpf = 64; // Bit clocks per frame: 48 or 64
   // Bit clock stands still outside frames
   initial begin
      bclk = 1'b0;
      lrclk = 1'b1;
      sd = 3'h0;
   end
   // Two lead-in bits then one frame of bpf bits, 80 ns bit period
   task automatic send(input logic [2:0] fmt, input logic [143:0] s);
      int wl, off, i;
      logic lft;
      wl = (fmt == 3'h0 || fmt == 3'h3 || fmt == 3'h7) ? 16 : ((fmt == 3'h1 || fmt == 3'h4) ? 20 : 24);
      lft = !(fmt >= 3'h3 && fmt <= 3'h5);
      off = fmt <= 3'h2 ? bpf / 2 - wl : (fmt <= 3'h5 ? 1 : 0);
      for (int p = -2; p < bpf; p++) begin
         lrclk = (p >= 0 && p < bpf / 2) ? lft : !lft;
         i = p % (bpf / 2) - off;
         // Unused slots toggle so stale or unmasked bits show
         for (int n = 0; n < 3; n++)
            sd[n] = (p >= 0 && i >= 0 && i < wl) ? s[143 - 24 * (2 * n + p / (bpf / 2)) - i] : p[0];
         #40 bclk = 1'b1;
         #40 bclk = 1'b0;
      end
      sd = ~sd; // Released lines do not hold their last value
   endtask
endmodule // sixrx_src
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the six-channel serial audio receiver.
// Assumes the source model and checker files compile before it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int INIT = 50; // Short init for simulation
   logic mclk = 0, rst = 1, power_down_control = 1, master_sel = 0, double_speed = 0, master_clock_in = 0;
   logic mck_en = 0, drift_seen = 0;
   logic [2:0] fmt = 3'h7; // Starts on the frame mode
   logic [143:0] smp = 144'h8012_347f_edcb_c3a5_5a3c_5aa5_f00f_0f0f_f0f1;
   int fail_count = 0, check_count = 0, vld_cnt = 0, rec_cnt = 0, mck_half = 20;
   wire logic bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe, src_bclk, src_lr;
   wire logic sample_valid_q, ready_q, recovery_q, master_mode_q, drift_q;
   wire logic [23:0] ch1_q, ch2_q, ch3_q, ch4_q, ch5_q, ch6_q;
   wire logic [1:0] speed_q;
   wire logic [3:0] fast_mult_q;
   wire logic [2:0] sd;
   // Pin level: the receiver drives clocks only when enabled
   wire logic bclk_w = bit_clock_oe ? bit_clock_out : src_bclk;
   wire logic lr_w = frame_clock_oe ? frame_clock_out : src_lr;
   sixrx_receiver #(.INIT_CYCLES(INIT)) u_sixrx_receiver (.mclk, .rst, .power_down_control, .master_sel,
      .double_speed, .master_clock_in, .format_select_bit2(fmt[2]), .format_select_bit1(fmt[1]),
      .format_select_bit0(fmt[0]), .bit_clock_in(bclk_w), .bit_clock_out, .bit_clock_oe, .frame_clock_in(lr_w),
      .frame_clock_out, .frame_clock_oe, .serial_in_line_a(sd[0]), .serial_in_line_b(sd[1]),
      .serial_in_line_c(sd[2]), .ch1_q, .ch2_q, .ch3_q, .ch4_q, .ch5_q, .ch6_q, .sample_valid_q, .ready_q,
      .recovery_q, .speed_q, .fast_mult_q, .volume_q(), .mclk_ratio_q(), .automute_q(), .deemph_q(),
      .dc_offset_q(), .delay_q(), .master_mode_q, .drift_q);
   sixrx_src u_sixrx_src (.bclk(src_bclk), .lrclk(src_lr), .sd);
   initial forever #5 mclk = ~mclk;
   // Audio master clock; gated to test the deferred start
   initial forever #(mck_half) if (mck_en) master_clock_in = ~master_clock_in;
   // Pulse counters and drift latch
   always @(posedge mclk) begin
      if (sample_valid_q === 1'b1) vld_cnt++;
      if (recovery_q === 1'b1) rec_cnt++;
      if (drift_q === 1'b1) drift_seen = 1;
   end
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic wait_ready();
      for (int n = 0; n < 3000 && ready_q !== 1'b1; n++) @(negedge mclk);
      check(ready_q === 1'b1, "ready never rose");
   endtask
   // One frame; stored words are MSB aligned, low bits masked
   task automatic frame(input logic [2:0] c, input logic [23:0] m);
      int v;
      v = vld_cnt;
      smp = {smp[139:0], smp[143:140]}; // New data each frame
      u_sixrx_src.send(c, smp);
      repeat (8) @(negedge mclk);
      check(vld_cnt > v, "no sample valid");
      check({ch1_q, ch2_q, ch3_q, ch4_q, ch5_q, ch6_q} === (smp & {6{m}}), "sample mismatch");
   endtask
   task automatic set_fmt(input logic [2:0] c);
      int r;
      r = rec_cnt;
      fmt = c;
      repeat (4) @(negedge mclk);
      check(rec_cnt == r + 1 && ready_q === 1'b0, "no recovery");
      wait_ready();
   endtask
   task automatic t_init();
      int n;
      repeat (16) @(negedge mclk);
      rst = 0;
      repeat (100) @(negedge mclk);
      check(ready_q === 1'b0, "ready without master clock");
      mck_en = 1;
      for (n = 0; n < 3000 && ready_q !== 1'b1; n++) @(negedge mclk);
      check(ready_q === 1'b1 && n >= INIT && master_mode_q === 1'b0, "init wrong");
      $display("test init done");
   endtask
   task automatic t_formats();
      logic [23:0] m [8] = '{24'hff_ff00, 24'hff_fff0, 24'hff_ffff, 24'hff_ff00, 24'hff_fff0, 24'hff_ffff,
         24'hff_ffff, 24'hff_ff00};
      for (int c = 0; c < 8; c++) begin
         set_fmt(c[2:0]);
         frame(c[2:0], m[c]);
      end
      // 48 bits per frame; the first frame only teaches the receiver its length
      set_fmt(3'h0);
      u_sixrx_src.bpf = 48;
      u_sixrx_src.send(3'h0, smp);
      @(negedge mclk);
      frame(3'h0, 24'hff_ff00);
      u_sixrx_src.bpf = 64;
      $display("test formats done");
   endtask
   task automatic t_speed();
      set_fmt(3'h3);
      double_speed = 1;
      repeat (2) frame(3'h3, 24'hff_ff00);
      check(speed_q === 2'h1 && fast_mult_q === 4'h4, "double speed");
      double_speed = 0;
      drift_seen = 0;
      mck_half = 50;
      repeat (3) frame(3'h3, 24'hff_ff00);
      check(speed_q === 2'h2 && fast_mult_q === 4'h2, "quad speed");
      check(drift_seen === 1'b1, "no drift");
      mck_half = 20;
      repeat (2) frame(3'h3, 24'hff_ff00);
      check(speed_q === 2'h0 && fast_mult_q === 4'h8, "normal speed");
      $display("test speed done");
   endtask
   task automatic t_pdn();
      int v;
      power_down_control = 0;
      repeat (2) @(negedge mclk);
      v = vld_cnt;
      u_sixrx_src.send(3'h3, smp);
      @(negedge mclk);
      check(ready_q === 1'b0 && vld_cnt == v, "traffic taken in power down");
      power_down_control = 1;
      wait_ready();
      frame(3'h3, 24'hff_ff00);
      $display("test power down done");
   endtask
   // Reset around each mode change, as the system must
   task automatic t_master();
      for (int k = 1; k >= 0; k--) begin
         rst = 1;
         master_sel = k[0];
         repeat (16) @(negedge mclk);
         rst = 0;
         wait_ready();
         check(master_mode_q === k[0] && bit_clock_oe === k[0] && frame_clock_oe === k[0], "mode");
         repeat (600) @(negedge mclk);
      end
      $display("test master done");
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog well beyond the expected 120 us run
   initial begin
      #400_000;
      fail_count++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      wrap_up();
   end
   initial begin
      t_init();
      t_formats();
      t_speed();
      t_pdn();
      t_master();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
